// *** include/ias_pkg.sv ***
// Purpose: shared types and constants for the interrupt acknowledge sequencer
// Assumes: one 25 MHz clock, active-low asynchronous reset
// Notes:   pins with a trailing slash on the board are carried as *_b here
package ias_pkg;
  localparam int CLK_PERIOD_NS  = 40;
  localparam int VEC_W          = 8;
  localparam int CASC_W         = 3;
  localparam int NUM_IRQ        = 8;
  localparam int VEC_SHIFT      = 2;
  localparam logic [4:0] VEC_BASE_RST = 5'h08;
  localparam logic [7:0] IRQ_MODE_RST = 8'h40;
  localparam logic [2:0] SYNC_RST     = 3'h0;

  typedef enum {
    IAS_IDLE,
    IAS_ACK1,
    IAS_GAP,
    IAS_ACK2,
    IAS_DONE
  } ias_state_t;

  typedef struct packed {
    logic        local_vector_buffer_enable_b;
    logic        bus_vector_driver_enable_b;
    logic        controller_data_enable_b;
    logic        first_ack_ready_flag_b;
    logic        cpu_ready;
  } ias_enables_t;
endpackage

// *** hw/ias_sync.sv ***
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: input may change at any time relative to clk
// Notes:   stage one is read only by stage two
`timescale 1ns/1ns
`default_nettype none
module ias_sync
  import ias_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] d,
  input  wire logic [W-1:0] rst_val,
  output var  logic [W-1:0] q
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic         armed;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else if (!armed) begin
      // Stages two and three start at idle, so no false change after reset
      s1 <= d;
      s2 <= rst_val;
      s3 <= rst_val;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Output moves only when stages two and three agree
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q     <= '0;
      armed <= 1'b0;
    end else if (!armed) begin
      q     <= rst_val;
      armed <= 1'b1;
    end else if (s2 == s3) begin
      q <= s3;
    end
  end
endmodule
`default_nettype wire

// *** hw/ias_top.sv ***
// Purpose: interrupt request and two-strobe acknowledge sequencing
// Assumes: CPU status and strobe pins arrive asynchronously
// Notes:   vector fills the whole 8-bit data output, no spare bits
`timescale 1ns/1ns
`default_nettype none
module ias_top
  import ias_pkg::*;
#(
  parameter int            N_IRQ     = NUM_IRQ,
  parameter logic [4:0]    VEC_BASE  = VEC_BASE_RST,
  parameter logic [7:0]    BUS_MODE  = IRQ_MODE_RST
) (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic [N_IRQ-1:0]  irq_lines,
  input  wire logic              int_ack_strobe_b,
  input  wire logic              addr_latch_strobe,
  input  wire logic              nmi_active,
  input  wire logic              cpu_int_enable,
  input  wire logic              eoi_pulse,
  input  wire logic              bus_transfer_ack_b,
  input  wire logic [VEC_W-1:0]  bus_low_data_lines_b,
  output var  logic              cpu_irq_input,
  output var  logic              bus_request,
  output var  logic              bus_lock_b,
  output var  logic              cascade_enable_status,
  output var  logic              qualified_cascade_enable_b,
  output var  logic [CASC_W-1:0] cpu_addr_bits_8_to_10,
  output var  logic [CASC_W-1:0] bus_addr_lines_8_to_10_b,
  output var  logic [VEC_W-1:0]  cpu_data,
  output var  logic [VEC_W+1:0]  restart_addr,
  output var  logic              local_vectored_mode,
  output var  logic              bus_vectored_mode,
  output var  ias_enables_t      enables
);
  ias_state_t         state;
  logic [N_IRQ-1:0]   in_service;
  logic [CASC_W-1:0]  chosen;
  logic [CASC_W-1:0]  next_chosen;
  logic               next_valid;
  logic [N_IRQ+2:0]   raw_in;
  logic [N_IRQ+2:0]   sync_q;
  logic [N_IRQ-1:0]   irq_s;
  logic               ack_s;
  logic               ale_s;
  logic               ack_d;
  logic               ale_d;
  logic               ack_fall;
  logic               ack_rise;
  logic               ale_fall;
  logic               is_bus;
  logic [CASC_W-1:0]  casc_hold;

  // Strobe and slave ack carried asserted-high inside, so reset matches idle
  assign raw_in = {~int_ack_strobe_b, addr_latch_strobe, ~bus_transfer_ack_b, irq_lines};

  ias_sync #(.W(N_IRQ + 3)) u_sync (
    .clk     (clk),
    .rst_b   (rst_b),
    .d       (raw_in),
    .rst_val ('0),
    .q       (sync_q)
  );
  assign irq_s    = sync_q[N_IRQ-1:0];
  assign ale_s    = sync_q[N_IRQ+1];
  assign ack_s    = sync_q[N_IRQ+2];
  assign ack_fall = !ack_d && ack_s;
  assign ack_rise = ack_d && !ack_s;
  assign ale_fall = ale_d && !ale_s;
  assign is_bus   = BUS_MODE[chosen];

  // Lowest line number wins; must beat every line already in service
  function automatic logic [CASC_W:0] pick(input logic [N_IRQ-1:0] req,
                                           input logic [N_IRQ-1:0] isr);
    logic [CASC_W:0] r;
    logic            blocked;
    r       = '0;
    blocked = 1'b0;
    for (int i = 0; i < N_IRQ; i++) begin
      if (isr[i]) blocked = 1'b1;
      if (!blocked && req[i] && !r[CASC_W] && !isr[i]) r = {1'b1, CASC_W'(i)};
    end
    return r;
  endfunction

  always_comb begin
    {next_valid, next_chosen} = pick(irq_s, in_service);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_d <= 1'b0;
      ale_d <= 1'b0;
    end else begin
      ack_d <= ack_s;
      ale_d <= ale_s;
    end
  end

  // Sequence: each strobe is counted on its falling edge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= IAS_IDLE;
    end else begin
      case (state)
        IAS_IDLE: if (ack_fall && cpu_irq_input && !nmi_active && cpu_int_enable) begin
          state <= IAS_ACK1;
        end
        IAS_ACK1: if (ack_rise) begin
          state <= IAS_GAP;
        end
        IAS_GAP: if (ack_fall) begin
          state <= IAS_ACK2;
        end
        IAS_ACK2: if (ack_rise) begin
          state <= IAS_DONE;
        end
        IAS_DONE: state <= IAS_IDLE;
        default: state <= IAS_IDLE;
      endcase
    end
  end

  // Frozen choice: cannot change from first strobe to vector delivery
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      chosen <= '0;
    end else if (state == IAS_IDLE && next_valid) begin
      chosen <= next_chosen;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      in_service    <= '0;
      cpu_irq_input <= 1'b0;
    end else begin
      if (state == IAS_DONE) begin
        in_service[chosen] <= 1'b1;
      end else if (eoi_pulse) begin
        in_service <= '0;
      end
      cpu_irq_input <= (state == IAS_IDLE) && next_valid;
    end
  end

  // Bus owned and locked over both cycles, whatever the mode
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bus_request           <= 1'b0;
      bus_lock_b            <= 1'b1;
      cascade_enable_status <= 1'b0;
    end else begin
      bus_request           <= state inside {IAS_ACK1, IAS_GAP, IAS_ACK2};
      bus_lock_b            <= !(state inside {IAS_ACK1, IAS_GAP, IAS_ACK2});
      cascade_enable_status <= (state == IAS_ACK1);
    end
  end

  // Pending flop: set by first strobe, cleared by second
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      enables <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
    end else begin
      if (state == IAS_IDLE && ack_fall && cpu_irq_input && !nmi_active && cpu_int_enable) begin
        enables.first_ack_ready_flag_b <= 1'b0;
      end else if (state == IAS_GAP && ack_fall) begin
        enables.first_ack_ready_flag_b <= 1'b1;
      end
      enables.controller_data_enable_b <=
        !((state == IAS_ACK2 && !is_bus) || (state inside {IAS_ACK1, IAS_GAP, IAS_ACK2} && is_bus));
      enables.local_vector_buffer_enable_b <= !(state == IAS_ACK2 && !is_bus);
      enables.bus_vector_driver_enable_b <=
        !(state inside {IAS_ACK1, IAS_GAP, IAS_ACK2} && is_bus);
      enables.cpu_ready <= (state == IAS_ACK1) ||
                           (state == IAS_ACK2 && (!is_bus || sync_q[N_IRQ]));
    end
  end

  // Cascade code on address bits while qualified enable active
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      qualified_cascade_enable_b <= 1'b1;
      cpu_addr_bits_8_to_10      <= '0;
      casc_hold                  <= '0;
      bus_addr_lines_8_to_10_b   <= '1;
    end else begin
      qualified_cascade_enable_b <= !(state == IAS_ACK1 && is_bus);
      cpu_addr_bits_8_to_10      <= (state == IAS_ACK1 && is_bus) ? chosen : '0;
      if (ale_fall && state == IAS_ACK1 && is_bus) begin
        casc_hold                <= chosen;
        bus_addr_lines_8_to_10_b <= ~chosen;
      end else if (state == IAS_DONE) begin
        bus_addr_lines_8_to_10_b <= '1;
      end
    end
  end

  // Vector: local from base and line, bus from inverted slave data
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cpu_data            <= '0;
      restart_addr        <= '0;
      local_vectored_mode <= 1'b0;
      bus_vectored_mode   <= 1'b0;
    end else begin
      local_vectored_mode <= !is_bus;
      bus_vectored_mode   <= is_bus;
      if (state == IAS_ACK2 && !is_bus) begin
        cpu_data     <= {VEC_BASE, chosen};
        restart_addr <= {VEC_BASE, chosen, 2'b00};
      // Taken once: slave lets go before its ack leaves the synchroniser
      end else if (state == IAS_ACK2 && is_bus && sync_q[N_IRQ] && !enables.cpu_ready) begin
        cpu_data     <= ~bus_low_data_lines_b;
        restart_addr <= {~bus_low_data_lines_b, 2'b00};
      end
    end
  end

  lock_span_a: assert property (@(posedge clk) disable iff (!rst_b)
    (state == IAS_GAP) |=> !bus_lock_b) else $error("lock dropped between strobes");
  ready_pair_a: assert property (@(posedge clk) disable iff (!rst_b)
    (state == IAS_ACK1) |=> enables.cpu_ready) else $error("no ready in first cycle");
  irq_gate_a: assert property (@(posedge clk) disable iff (!rst_b)
    (state != IAS_IDLE) |=> !cpu_irq_input) else $error("request during acknowledge");
  choice_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    (state inside {IAS_ACK1, IAS_GAP}) |=> $stable(chosen)) else $error("choice moved");
  local_den_a: assert property (@(posedge clk) disable iff (!rst_b)
    (state == IAS_ACK2 && !is_bus) |=> !enables.local_vector_buffer_enable_b)
    else $error("local buffer off");
  bus_den_a: assert property (@(posedge clk) disable iff (!rst_b)
    (state == IAS_ACK1 && is_bus) |=> !enables.bus_vector_driver_enable_b)
    else $error("bus driver off");
  casc_route_a: assert property (@(posedge clk) disable iff (!rst_b)
    (state == IAS_ACK1 && is_bus) |=> cpu_addr_bits_8_to_10 == $past(chosen))
    else $error("cascade code missing");
  vec_scale_a: assert property (@(posedge clk) disable iff (!rst_b)
    (state == IAS_ACK2 && !is_bus) |=> restart_addr == {cpu_data, 2'b00})
    else $error("restart not vector times four");
endmodule
`default_nettype wire

// *** verification/ias_slave_model.sv ***
// Purpose: slave controller on the system bus answering the second strobe
// Assumes: strobe and latched cascade code are seen on clk
// Notes:   released lines float high through the bus pull-ups
`timescale 1ns/1ns
`default_nettype none
module ias_slave_model
  import ias_pkg::*;
#(
  parameter logic [2:0] MY_CODE = 3'h6
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             int_ack_strobe_b,
  input  wire logic [2:0]       bus_addr_lines_8_to_10_b,
  input  wire logic [VEC_W-1:0] vec,
  input  wire logic [2:0]       lag,
  output var  logic             bus_transfer_ack_b,
  output var  logic [VEC_W-1:0] bus_low_data_lines_b
);
  logic       strobe_q;
  logic       busy;
  logic [2:0] wait_cnt;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      strobe_q <= 1'b1;
      busy <= 1'b0;
      wait_cnt <= 3'h0;
      bus_transfer_ack_b <= 1'b1;
      bus_low_data_lines_b <= 8'hFF;
    end else begin
      strobe_q <= int_ack_strobe_b;
      if (strobe_q && !int_ack_strobe_b && ~bus_addr_lines_8_to_10_b == MY_CODE) begin
        busy <= 1'b1;
        wait_cnt <= lag;
      end else if (int_ack_strobe_b) begin
        // Lines let go at once, pull-ups bring them high
        busy <= 1'b0;
        bus_transfer_ack_b <= 1'b1;
        bus_low_data_lines_b <= 8'hFF;
      end else if (busy && wait_cnt != 3'h0) begin
        wait_cnt <= wait_cnt - 3'h1;
      end else if (busy) begin
        bus_transfer_ack_b <= 1'b0;
        bus_low_data_lines_b <= ~vec;
      end
    end
  end
endmodule
`default_nettype wire

// *** verification/ias_tb_top.sv ***
// Purpose: self-checking bench for the acknowledge sequencer
// Assumes: strobes driven on clk, slave lag random
// Notes:   vector results pass through a queue to a monitor
`timescale 1ns/1ns
`default_nettype none
module ias_tb_top
  import ias_pkg::*;
;
  logic         clk;
  logic         rst_b = 1'b0;
  logic [7:0]   irq = 8'h00;
  logic         stb_b = 1'b1;
  logic         ale = 1'b0;
  logic         nmi = 1'b0;
  logic         ien = 1'b1;
  logic         eoi = 1'b0;
  logic         slv_ack_b;
  logic [7:0]   bdat_b;
  logic [7:0]   vec = 8'h00;
  logic [2:0]   lag = 3'h0;
  logic         irq_out, breq, lock_b, ces, qce_b, lvm, bvm;
  logic [2:0]   caddr, baddr_b;
  logic [7:0]   data;
  logic [9:0]   rst_addr;
  ias_enables_t en;
  int           n_errors = 0;
  int           comparisons = 0;
  integer       seed = 32'hbad6;
  int           r, k, i;
  logic [19:0]  expq[$];
  logic         a2 = 1'b0, a2_q = 1'b0, a2_done = 1'b0;

  ias_top u_ias_top (.clk(clk), .rst_b(rst_b), .irq_lines(irq), .int_ack_strobe_b(stb_b),
    .addr_latch_strobe(ale), .nmi_active(nmi), .cpu_int_enable(ien), .eoi_pulse(eoi),
    .bus_transfer_ack_b(slv_ack_b), .bus_low_data_lines_b(bdat_b), .cpu_irq_input(irq_out),
    .bus_request(breq), .bus_lock_b(lock_b), .cascade_enable_status(ces),
    .qualified_cascade_enable_b(qce_b), .cpu_addr_bits_8_to_10(caddr),
    .bus_addr_lines_8_to_10_b(baddr_b), .cpu_data(data), .restart_addr(rst_addr),
    .local_vectored_mode(lvm), .bus_vectored_mode(bvm), .enables(en));

  ias_slave_model u_ias_slave_model (.clk(clk), .rst_b(rst_b), .int_ack_strobe_b(stb_b),
    .bus_addr_lines_8_to_10_b(baddr_b), .vec(vec), .lag(lag),
    .bus_transfer_ack_b(slv_ack_b), .bus_low_data_lines_b(bdat_b));

  initial begin
    clk = 1'b0;
    forever #(CLK_PERIOD_NS/2) clk = ~clk;
  end

  task chk(input logic [19:0] got, input logic [19:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task final_report;
    if (n_errors == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Bounded so a dead sequencer ends in a mismatch, not a hang
  task wait_rdy(input logic lvl);
    for (i = 0; i < 60 && en.cpu_ready !== lvl; i++) @(posedge clk);
  endtask

  task run_ack(input logic bus);
    int          line;
    logic [7:0]  v;
    line = bus ? 6 : 5;
    v = bus ? vec : {VEC_BASE_RST, 3'h5};
    irq[line] <= 1'b1;
    for (i = 0; i < 20 && irq_out !== 1'b1; i++) @(posedge clk);
    chk(irq_out, 1'b1);
    stb_b <= 1'b0;
    wait_rdy(1'b1);
    @(posedge clk);
    chk({lock_b, breq, en.first_ack_ready_flag_b, irq_out, ces}, 5'b01001);
    chk({qce_b, caddr, en.bus_vector_driver_enable_b}, bus ? 5'b01100 : 5'b10001);
    chk({lvm, bvm, en.controller_data_enable_b}, bus ? 3'b010 : 3'b101);
    if (bus) begin
      ale <= 1'b1;
      cyc(2);
      ale <= 1'b0;
      cyc(6);
      chk(baddr_b, {17'h0, ~3'h6});
    end
    // Request withdrawn after the first strobe; vector must still come
    irq[line] <= 1'b0;
    stb_b <= 1'b1;
    wait_rdy(1'b0);
    expq.push_back({bus, ~bus, v, v, 2'b00});
    cyc(2);
    stb_b <= 1'b0;
    wait_rdy(1'b1);
    chk(en.controller_data_enable_b, 1'b0);
    cyc(3);
    stb_b <= 1'b1;
    for (i = 0; i < 20 && lock_b !== 1'b1; i++) @(posedge clk);
    chk({lock_b, en.first_ack_ready_flag_b}, 2'b11);
    // In local runs, line 5 still in service must hold off the lower line 6
    irq[6] <= !bus;
    cyc(8);
    chk(irq_out, 1'b0);
    irq[6] <= 1'b0;
    cyc(6);
    eoi <= 1'b1;
    @(posedge clk);
    eoi <= 1'b0;
    cyc(4);
  endtask

  always @(posedge clk) begin
    a2 = rst_b && en.cpu_ready === 1'b1 && en.first_ack_ready_flag_b === 1'b1 && lock_b === 1'b0;
    if (a2 && a2_q && !a2_done) begin
      a2_done = 1'b1;
      if (expq.size() == 0) chk(20'h0, 20'hFFFFF);
      else chk({en.local_vector_buffer_enable_b, en.bus_vector_driver_enable_b, data, rst_addr}, expq.pop_front());
    end
    if (!a2) a2_done = 1'b0;
    a2_q = a2;
  end

  initial begin
    repeat (19) @(posedge clk);
    chk({en, lock_b, baddr_b}, {5'b11110, 1'b1, 3'h7});
    @(posedge clk);
    rst_b <= 1'b1;
    cyc(6);
    irq[5] <= 1'b1;
    // Request must already stand, or the refused strobes prove nothing
    cyc(8);
    chk(irq_out, 1'b1);
    for (k = 0; k < 2; k++) begin
      nmi <= (k == 0);
      ien <= (k == 0);
      stb_b <= 1'b0;
      cyc(10);
      chk({lock_b, en.cpu_ready}, 2'b10);
      stb_b <= 1'b1;
      cyc(4);
    end
    nmi <= 1'b0;
    ien <= 1'b1;
    irq[5] <= 1'b0;
    cyc(6);
    for (k = 0; k < 6; k++) begin
      r = $random(seed);
      vec <= r[7:0];
      lag <= r[10:8];
      @(posedge clk);
      run_ack(k[0]);
    end
    cyc(10);
    chk(20'(expq.size()), 20'h0);
    final_report;
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    final_report;
  end
endmodule
`default_nettype wire
